// ==== hw/tpf_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the test pattern filler.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`ifndef TPF_REGS_SVH
`define TPF_REGS_SVH

// Register byte offsets.
`define TPF_CTRL_OFS 8'h00
`define TPF_LEN_OFS 8'h04
`define TPF_ADDR_LO_OFS 8'h08
`define TPF_ADDR_HI_OFS 8'h0C
`define TPF_STATUS_OFS 8'h10

// Control register fields.
`define TPF_CTRL_WRITE_BIT 0
`define TPF_CTRL_READ_BIT 1
`define TPF_CTRL_SEL_LSB 4
`define TPF_CTRL_SEL_MSB 5

// Status register fields.
`define TPF_STAT_BUSY_BIT 0
`define TPF_STAT_READ_BIT 1
`define TPF_STAT_STATE_LSB 4
`define TPF_STAT_STATE_MSB 6
`define TPF_STAT_CNT_LSB 16
`define TPF_STAT_CNT_MSB 28

// Reset values.
`define TPF_LEN_RST 32'h0000_0000
`define TPF_ADDR_RST 48'h0000_0000_0000
`define TPF_SEL_RST 2'h0

// Stream geometry and timing counts.
`define TPF_BLOCK_WORDS 512
`define TPF_LAST_WORD 10'h1FF
`define TPF_FIFO_DEPTH_LOG2 12
`define TPF_SPACE_LIMIT 13'h0C00
`define TPF_UNITS_PER_BLOCK 48'h0000_0000_0008
`define TPF_CLEAR_CYCLES 4
`define TPF_HDR_TAG 16'h4B42

`endif

// ==== hw/tpf_pkg.sv ====
// Types shared by the test pattern filler and its lookahead FIFO.
// Assumes the constants of tpf_regs.svh are included where numbers are needed.
package tpf_pkg;

	typedef enum logic [2:0] {
		fill_idle = 3'h0,
		fill_clear = 3'h1,
		fill_wait_clear = 3'h2,
		fill_wait_space = 3'h3,
		fill_header = 3'h4,
		fill_pattern = 3'h5
	} tpf_fill_state_e;

	typedef enum logic [1:0] {
		tpf_patt_inc = 2'h0,
		tpf_patt_dec = 2'h1,
		tpf_patt_lfsr = 2'h2,
		tpf_patt_toggle = 2'h3
	} tpf_pattern_e;

endpackage : tpf_pkg

// ==== hw/tpf_lookahead_fifo.sv ====
// First-word-fall-through FIFO that buffers generated test words.
// Assumes one clock; a clear keeps the FIFO busy for a few cycles before writes are accepted.
`timescale 1ns/1ps
`include "tpf_regs.svh"

module tpf_lookahead_fifo
	import tpf_pkg::*;
#(
	parameter int WIDTH = 64,
	parameter int DEPTH_LOG2 = `TPF_FIFO_DEPTH_LOG2,
	parameter int CLEAR_CYCLES = `TPF_CLEAR_CYCLES
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic clear,
	output logic reset_pending,
	output logic write_full,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	output logic [WIDTH-1:0] rd_data,
	output logic rd_valid,
	output logic [DEPTH_LOG2:0] fill_count
);

	localparam int DEPTH = 1 << DEPTH_LOG2;

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [DEPTH_LOG2-1:0] wr_ptr_r;
	logic [DEPTH_LOG2-1:0] rd_ptr_r;
	logic [DEPTH_LOG2:0] mem_cnt_r;
	logic [DEPTH_LOG2:0] mem_cnt_nxt;
	logic out_valid_r;
	logic [WIDTH-1:0] out_r;
	logic [3:0] pend_cnt_r;
	wire do_wr;
	wire do_rd;
	wire load_out;
	wire [DEPTH_LOG2:0] total;

	// The output register holds the head word, so reads see data in the same cycle.
	assign do_rd = rd_en && out_valid_r;
	assign load_out = (mem_cnt_r != '0) && (!out_valid_r || do_rd);
	assign total = mem_cnt_r + {{DEPTH_LOG2{1'b0}}, out_valid_r};
	assign reset_pending = (pend_cnt_r != 4'h0);
	assign write_full = reset_pending || (total >= (DEPTH_LOG2+1)'(DEPTH));
	assign do_wr = wr_en && !write_full;
	assign mem_cnt_nxt = mem_cnt_r + (DEPTH_LOG2+1)'(do_wr) - (DEPTH_LOG2+1)'(load_out);
	assign fill_count = total;
	assign rd_data = out_r;
	assign rd_valid = out_valid_r;

	always_ff @(posedge clk)
	begin
		if (do_wr)
		begin
			mem_r[wr_ptr_r] <= wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset || clear)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			mem_cnt_r <= '0;
			out_valid_r <= 1'b0;
			out_r <= '0;
			pend_cnt_r <= 4'(CLEAR_CYCLES);
		end
		else
		begin
			wr_ptr_r <= wr_ptr_r + DEPTH_LOG2'(do_wr);
			rd_ptr_r <= rd_ptr_r + DEPTH_LOG2'(load_out);
			mem_cnt_r <= mem_cnt_nxt;
			if (load_out)
			begin
				out_r <= mem_r[rd_ptr_r];
				out_valid_r <= 1'b1;
			end
			else if (do_rd)
			begin
				out_valid_r <= 1'b0;
			end
			if (reset_pending)
			begin
				pend_cnt_r <= pend_cnt_r - 4'h1;
			end
		end
	end

endmodule : tpf_lookahead_fifo

// ==== hw/tpf_fill.sv ====
// Data-generation half of a storage test source: fills a lookahead FIFO with pattern words.
// Assumes a classic Wishbone master for setup and a command side that drains the FIFO.
//
// Function
// - In idle a test request latches length, start address and pattern, then clears.
// - The clear state pulses the FIFO clear for exactly one cycle.
// - Wait until FIFO reset-pending and write-full are both low.
// - Wait until at least 8 KB of FIFO space is free, then write a header.
// - The header state prepares one 64-bit header word per 4 KB block in one cycle.
// - Each block holds the write strobe high for 512 consecutive cycles.
// - The next pattern word is computed one cycle ahead of its write.
// - At the 511th word of the final block, return to idle after finishing it.
// - If not last and space below 8 KB, finish the block then wait for space.
// - If not last and space suffices, go straight to the header without a strobe gap.
// - The FIFO holds 32 KB, eight blocks; filling pauses below 8 KB free.
// - Once draining starts, at least 512 words are ready for continuous reads; the filler does not gate reads, so fifo_word_valid rises with the first word.
// - Words enter the FIFO only in whole 4 KB bursts.
// - A first-word-fall-through FIFO buffers words while the host core stalls.
// - In a write test the FIFO words leave unchanged as host write data.
// - In a read test the pattern is still generated for checking returned data.
// - Space is sufficient when the fill count is below 3072 words.
// - In a read test the host read-valid strobe reads the FIFO directly.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "tpf_regs.svh"

module tpf_fill
	import tpf_pkg::*;
#(
	parameter int LEN_W = 32,
	parameter int ADDR_W = 48,
	parameter int DEPTH_LOG2 = `TPF_FIFO_DEPTH_LOG2
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic fifo_read_strobe,
	input wire logic host_read_valid,
	output logic [63:0] fifo_read_word,
	output logic [63:0] host_write_word,
	output logic fifo_word_valid,
	output logic [DEPTH_LOG2:0] fifo_fill_count,
	output logic test_is_read,
	output logic fill_busy
);

	localparam int RBC_W = LEN_W - 3;

	// Register bus state.
	logic wb_ack_r;
	logic [31:0] wb_dat_r_r;
	logic [LEN_W-1:0] len_reg_r;
	logic [ADDR_W-1:0] addr_reg_r;
	logic [1:0] sel_reg_r;
	logic write_test_request_r;
	logic read_test_request_r;

	// Fill engine state.
	tpf_fill_state_e data_fill_state_r;
	tpf_fill_state_e data_fill_state_nxt;
	tpf_pattern_e pattern_select_r;
	logic test_is_read_r;
	logic [RBC_W-1:0] remaining_block_counter_r;
	logic [ADDR_W-1:0] block_addr_r;
	logic [63:0] patt_state_r;
	logic [63:0] pattern_word_r;
	logic fifo_write_strobe_r;
	logic fifo_clear_r;
	logic [9:0] word_cnt_r;

	// FIFO side.
	wire fifo_reset_pending;
	wire fifo_write_full;
	wire fifo_rd_en;
	wire [DEPTH_LOG2:0] fifo_cnt;
	wire [63:0] fifo_rd_data;
	wire fifo_rd_valid;

	// Bus decode.
	wire bus_req;
	wire bus_wr;
	wire hit_ctrl;
	wire hit_len;
	wire hit_addr_lo;
	wire hit_addr_hi;
	wire hit_status;
	wire [31:0] status_word;
	wire [31:0] addr_hi_word;
	wire [31:0] rd_mux;
	wire [31:0] len_merged;
	wire [31:0] addr_lo_merged;
	wire [31:0] addr_hi_merged;

	// Engine decode.
	wire start_req;
	wire start_ok;
	wire space_ok;
	wire last_block;
	wire last_word;
	wire [RBC_W-1:0] blocks_req;
	wire [63:0] patt_next;
	wire [63:0] patt_seed;
	wire [63:0] header_word;

	function automatic logic [31:0] tpf_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : tpf_merge

	function automatic logic [63:0] tpf_step(input logic [63:0] s, input tpf_pattern_e sel);
		logic [63:0] res;
		res = s;
		case (sel)
			tpf_patt_inc: res = s + 64'h0000_0000_0000_0001;
			tpf_patt_dec: res = s - 64'h0000_0000_0000_0001;
			tpf_patt_lfsr: res = {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
			default: res = ~s;
		endcase
		return res;
	endfunction : tpf_step

	// Classic Wishbone slave: ack one cycle after the request, dropped the cycle after.
	assign bus_req = wb_cyc && wb_stb && !wb_ack_r;
	assign bus_wr = bus_req && wb_we;
	assign hit_ctrl = (wb_adr == `TPF_CTRL_OFS);
	assign hit_len = (wb_adr == `TPF_LEN_OFS);
	assign hit_addr_lo = (wb_adr == `TPF_ADDR_LO_OFS);
	assign hit_addr_hi = (wb_adr == `TPF_ADDR_HI_OFS);
	assign hit_status = (wb_adr == `TPF_STATUS_OFS);
	assign len_merged = tpf_merge(len_reg_r[31:0], wb_dat_w, wb_sel);
	assign addr_lo_merged = tpf_merge(addr_reg_r[31:0], wb_dat_w, wb_sel);
	assign addr_hi_word = {16'h0000, addr_reg_r[ADDR_W-1:32]};
	assign addr_hi_merged = tpf_merge(addr_hi_word, wb_dat_w, wb_sel);

	// Status shows the engine state and the live FIFO fill level.
	assign status_word = {3'h0, 3'(fifo_cnt >> 10), fifo_cnt[9:0],
		9'h000, data_fill_state_r, 2'h0, test_is_read_r, fill_busy};

	assign rd_mux = hit_ctrl ? {26'h0000000, sel_reg_r, 4'h0} :
		hit_len ? len_reg_r[31:0] :
		hit_addr_lo ? addr_reg_r[31:0] :
		hit_addr_hi ? addr_hi_word :
		hit_status ? status_word : 32'h0000_0000;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wb_ack_r <= 1'b0;
			wb_dat_r_r <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_r <= bus_req;
			wb_dat_r_r <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			len_reg_r <= `TPF_LEN_RST;
			addr_reg_r <= `TPF_ADDR_RST;
			sel_reg_r <= `TPF_SEL_RST;
			write_test_request_r <= 1'b0;
			read_test_request_r <= 1'b0;
		end
		else
		begin
			write_test_request_r <= bus_wr && hit_ctrl && wb_sel[0] && wb_dat_w[`TPF_CTRL_WRITE_BIT];
			read_test_request_r <= bus_wr && hit_ctrl && wb_sel[0] && wb_dat_w[`TPF_CTRL_READ_BIT];
			if (bus_wr && hit_ctrl && wb_sel[0])
			begin
				sel_reg_r <= wb_dat_w[`TPF_CTRL_SEL_MSB:`TPF_CTRL_SEL_LSB];
			end
			if (bus_wr && hit_len)
			begin
				len_reg_r <= len_merged;
			end
			if (bus_wr && hit_addr_lo)
			begin
				addr_reg_r[31:0] <= addr_lo_merged;
			end
			if (bus_wr && hit_addr_hi)
			begin
				addr_reg_r[ADDR_W-1:32] <= addr_hi_merged[ADDR_W-33:0];
			end
		end
	end

	assign wb_ack = wb_ack_r;
	assign wb_dat_r = wb_dat_r_r;

	// A request with fewer than eight units has no whole block and is ignored.
	assign start_req = write_test_request_r || read_test_request_r;
	assign blocks_req = len_reg_r[LEN_W-1:3];
	assign start_ok = start_req && (blocks_req != '0);
	assign space_ok = (fifo_cnt < `TPF_SPACE_LIMIT);
	assign last_block = (remaining_block_counter_r == RBC_W'(1));
	assign last_word = (word_cnt_r == `TPF_LAST_WORD);
	assign patt_seed = {{(64-ADDR_W){1'b0}}, addr_reg_r} | 64'h0000_0000_0000_0001;
	assign patt_next = tpf_step(patt_state_r, pattern_select_r);
	assign header_word = {`TPF_HDR_TAG, block_addr_r};

	always_comb
	begin
		data_fill_state_nxt = data_fill_state_r;
		case (data_fill_state_r)
			fill_idle:
			begin
				if (start_ok)
				begin
					data_fill_state_nxt = fill_clear;
				end
			end
			fill_clear: data_fill_state_nxt = fill_wait_clear;
			fill_wait_clear:
			begin
				if (!fifo_reset_pending && !fifo_write_full)
				begin
					data_fill_state_nxt = fill_wait_space;
				end
			end
			fill_wait_space:
			begin
				if (space_ok)
				begin
					data_fill_state_nxt = fill_header;
				end
			end
			fill_header: data_fill_state_nxt = fill_pattern;
			fill_pattern:
			begin
				if (last_word)
				begin
					if (last_block)
					begin
						data_fill_state_nxt = fill_idle;
					end
					else if (!space_ok)
					begin
						data_fill_state_nxt = fill_wait_space;
					end
					else
					begin
						data_fill_state_nxt = fill_header;
					end
				end
			end
			default: data_fill_state_nxt = fill_idle;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			data_fill_state_r <= fill_idle;
			pattern_select_r <= tpf_patt_inc;
			test_is_read_r <= 1'b0;
			remaining_block_counter_r <= '0;
			block_addr_r <= '0;
			patt_state_r <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			data_fill_state_r <= data_fill_state_nxt;
			if (data_fill_state_r == fill_idle && start_ok)
			begin
				pattern_select_r <= tpf_pattern_e'(sel_reg_r);
				test_is_read_r <= !write_test_request_r;
				remaining_block_counter_r <= blocks_req;
				block_addr_r <= addr_reg_r;
				patt_state_r <= patt_seed;
			end
			else if (data_fill_state_r == fill_pattern)
			begin
				patt_state_r <= patt_next;
				if (last_word)
				begin
					remaining_block_counter_r <= remaining_block_counter_r - RBC_W'(1);
					block_addr_r <= block_addr_r + `TPF_UNITS_PER_BLOCK;
				end
			end
		end
	end

	// Word and strobe registers: the header cycle and 511 pattern cycles give 512 writes.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fifo_clear_r <= 1'b0;
			fifo_write_strobe_r <= 1'b0;
			pattern_word_r <= 64'h0000_0000_0000_0000;
			word_cnt_r <= 10'h000;
		end
		else
		begin
			fifo_clear_r <= (data_fill_state_nxt == fill_clear);
			if (data_fill_state_r == fill_header)
			begin
				pattern_word_r <= header_word;
				fifo_write_strobe_r <= 1'b1;
				word_cnt_r <= 10'h001;
			end
			else if (data_fill_state_r == fill_pattern)
			begin
				pattern_word_r <= patt_state_r;
				fifo_write_strobe_r <= 1'b1;
				word_cnt_r <= word_cnt_r + 10'h001;
			end
			else
			begin
				fifo_write_strobe_r <= 1'b0;
				word_cnt_r <= 10'h000;
			end
		end
	end

	// In a read test the host read-valid pulls one expected word per returned word.
	assign fifo_rd_en = test_is_read_r ? host_read_valid : fifo_read_strobe;

	tpf_lookahead_fifo #(
		.WIDTH(64),
		.DEPTH_LOG2(DEPTH_LOG2),
		.CLEAR_CYCLES(`TPF_CLEAR_CYCLES)
	) u_lookahead_fifo (
		.clk(clk),
		.reset(reset),
		.clear(fifo_clear_r),
		.reset_pending(fifo_reset_pending),
		.write_full(fifo_write_full),
		.wr_en(fifo_write_strobe_r),
		.wr_data(pattern_word_r),
		.rd_en(fifo_rd_en),
		.rd_data(fifo_rd_data),
		.rd_valid(fifo_rd_valid),
		.fill_count(fifo_cnt)
	);

	assign fifo_read_word = fifo_rd_data;
	assign host_write_word = fifo_rd_data;
	assign fifo_word_valid = fifo_rd_valid;
	assign fifo_fill_count = fifo_cnt;
	assign test_is_read = test_is_read_r;
	assign fill_busy = (data_fill_state_r != fill_idle);

endmodule : tpf_fill

// ==== testbench/tpf_fill_properties.sv ====
// Concurrent checks on the ports of the test pattern filler.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tpf_fill_properties
	import tpf_pkg::*;
#(
	parameter int DEPTH_LOG2 = 12
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	input wire logic [31:0] wb_dat_r,
	input wire logic wb_ack,
	input wire logic fifo_read_strobe,
	input wire logic host_read_valid,
	input wire logic [63:0] fifo_read_word,
	input wire logic [63:0] host_write_word,
	input wire logic fifo_word_valid,
	input wire logic [DEPTH_LOG2:0] fifo_fill_count,
	input wire logic test_is_read,
	input wire logic fill_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_req;
		wb_cyc && wb_stb && !wb_ack;
	endsequence
	// The last word of a test lands one cycle after the engine is back in idle.
	sequence s_idle3;
		!fill_busy [*3];
	endsequence
	AST_ACK_NEXT: assert property (s_req |=> wb_ack)
		else $error("bus request not answered in one cycle");
	AST_ACK_PULSE: assert property (wb_ack |=> !wb_ack)
		else $error("ack longer than one cycle");
	AST_DATA_IDLE: assert property (!wb_ack |-> wb_dat_r == 32'h0)
		else $error("read data not zero outside ack");
	AST_WRITE_FWD: assert property (host_write_word == fifo_read_word)
		else $error("host write word differs from fifo head");
	AST_COUNT_STEP: assert property (fifo_fill_count <= $past(fifo_fill_count) + 1)
		else $error("fill count grew by more than one word");
	AST_FILL_BUSY: assert property ($past(fifo_fill_count) < fifo_fill_count |-> $past(fill_busy, 2))
		else $error("fifo written while filler idle");
	AST_SPACE_LIMIT: assert property (fifo_fill_count <= 13'h0E10)
		else $error("filling went past the space limit");
	AST_IDLE_HOLD: assert property (s_idle3 |-> fifo_fill_count <= $past(fifo_fill_count))
		else $error("fifo grew after filling ended");
	AST_READ_HOLDS: assert property (fill_busy && $past(fill_busy) |-> $stable(test_is_read))
		else $error("test kind changed while busy");
endmodule : tpf_fill_properties

// ==== testbench/tpf_cmd_side.sv ====
// Model of the command side that drains the filler's lookahead FIFO.
// Assumes the filler pops its head on a strobe at an edge where the head is valid.
`timescale 1ns/1ps
module tpf_cmd_side
	import tpf_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic en,
	input wire logic rd_mode,
	input wire logic slow,
	input wire logic word_valid,
	output logic fifo_read_strobe,
	output logic host_read_valid
);
	logic [1:0] wait_r;
	logic pop_nxt;
	// When slow, the host core holds wait-request one cycle in four.
	assign pop_nxt = en && word_valid && !(slow && wait_r == 2'h3);
	always_ff @(posedge clk)
	begin
		wait_r <= reset ? 2'h0 : wait_r + 2'h1;
		fifo_read_strobe <= !reset && pop_nxt && !rd_mode;
		host_read_valid <= !reset && pop_nxt && rd_mode;
	end
endmodule : tpf_cmd_side

// ==== testbench/tpf_fill_tb_top.sv ====
// Self-checking bench of the test pattern filler over classic Wishbone.
// Assumes the command side model drains the FIFO and this module checks each popped word.
`timescale 1ns/1ps
`include "tpf_regs.svh"
module tpf_fill_tb_top
	import tpf_pkg::*;
;
	logic clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, fifo_read_strobe, host_read_valid;
	logic fifo_word_valid, test_is_read, fill_busy, en, rd_mode, slow;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, q;
	logic [63:0] fifo_read_word, host_write_word, pat;
	logic [12:0] fifo_fill_count;
	logic [47:0] blk;
	logic [1:0] mode;
	int errors = 0, n_compared = 0, idx, popped, cycles = 0;
	tpf_fill DUT (.clk(clk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack), .fifo_read_strobe(fifo_read_strobe), .host_read_valid(host_read_valid),
		.fifo_read_word(fifo_read_word), .host_write_word(host_write_word),
		.fifo_word_valid(fifo_word_valid), .fifo_fill_count(fifo_fill_count),
		.test_is_read(test_is_read), .fill_busy(fill_busy));
	tpf_cmd_side u_cmd (.clk(clk), .reset(reset), .en(en), .rd_mode(rd_mode), .slow(slow),
		.word_valid(fifo_word_valid), .fifo_read_strobe(fifo_read_strobe),
		.host_read_valid(host_read_valid));
	task close_out;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hF;
		wb_dat_w <= d;
		do
			@(posedge clk);
		while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb_xfer
	function automatic logic [63:0] nxt(input logic [63:0] s, input logic [1:0] m);
		case (m)
			2'h0: return s + 64'h1;
			2'h1: return s - 64'h1;
			2'h2: return {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
			default: return ~s;
		endcase
	endfunction : nxt
	// Expected stream: header with block address, then pattern words continuing across blocks.
	always @(posedge clk)
	begin
		cycles++;
		if (!reset && fifo_word_valid === 1'b1 && (fifo_read_strobe || host_read_valid))
		begin
			if (idx == 0)
				chk("header", {`TPF_HDR_TAG, blk}, fifo_read_word);
			else
			begin
				chk("pattern", pat, fifo_read_word);
				pat = nxt(pat, mode);
			end
			chk("host word", fifo_read_word, host_write_word);
			idx = (idx == 511) ? 0 : idx + 1;
			if (idx == 0)
				blk = blk + 48'h8;
			popped++;
		end
		if (cycles == 90000)
		begin
			errors++;
			$display("Error run length expected done seen hang");
			close_out;
		end
	end
	task run_test(input logic rd, input logic [1:0] m, input logic [31:0] len,
		input logic [47:0] a, input logic stall);
		en <= !stall;
		rd_mode <= rd;
		idx = 0;
		blk = a;
		pat = {16'h0, a} | 64'h1;
		mode = m;
		popped = 0;
		wb_xfer(1'b1, `TPF_LEN_OFS, len);
		wb_xfer(1'b1, `TPF_ADDR_LO_OFS, a[31:0]);
		wb_xfer(1'b1, `TPF_ADDR_HI_OFS, {16'h0, a[47:32]});
		wb_xfer(1'b1, `TPF_CTRL_OFS, {26'h0, m, 2'h0, rd, !rd});
		if (stall)
		begin
			while (fifo_fill_count < 13'h0C00)
				@(posedge clk);
			do
				wb_xfer(1'b0, `TPF_STATUS_OFS, 32'h0);
			while (q[6:4] !== 3'h3);
			chk("stop", 1, fifo_fill_count === 13'h0C00 || fifo_fill_count === 13'h0E00);
			wb_xfer(1'b1, `TPF_CTRL_OFS, 32'h2);
			wb_xfer(1'b0, `TPF_STATUS_OFS, 32'h0);
			chk("busy kind", 2'h1, q[1:0]);
			en <= 1'b1;
		end
		while (popped < len / 8 * 512)
			@(posedge clk);
		wb_xfer(1'b0, `TPF_STATUS_OFS, 32'h0);
		chk("status", {30'h0, rd, 1'b0}, q);
		$display("test done read %0d pattern %0d", rd, m);
	endtask : run_test
	initial
	begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end
	initial
	begin
		reset = 1'b1;
		{wb_cyc, wb_stb, wb_we, en, rd_mode, slow} = 6'h0;
		wb_adr = 8'h0;
		wb_sel = 4'hF;
		wb_dat_w = 32'h0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			wb_xfer(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", 32'h0, q);
		end
		$display("test done reset values");
		slow <= 1'b1;
		for (int m = 0; m < 4; m++)
			run_test(m[0], m[1:0], 32'h10, 48'h0A00_0000_0010 + 48'(m), 1'b0);
		wb_xfer(1'b1, `TPF_LEN_OFS, 32'h4);
		wb_xfer(1'b1, `TPF_CTRL_OFS, 32'h1);
		wb_xfer(1'b0, `TPF_STATUS_OFS, 32'h0);
		// An ignored start keeps the kind of the last real test, a read test here.
		chk("short start", 32'h2, q);
		$display("test done short length");
		run_test(1'b0, 2'h2, 32'h140, 48'h0000_0000_0100, 1'b1);
		close_out;
	end
endmodule : tpf_fill_tb_top
bind tpf_fill tpf_fill_properties #(.DEPTH_LOG2(DEPTH_LOG2)) u_props (.clk(clk), .reset(reset),
	.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
	.wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
	.fifo_read_strobe(fifo_read_strobe), .host_read_valid(host_read_valid),
	.fifo_read_word(fifo_read_word), .host_write_word(host_write_word),
	.fifo_word_valid(fifo_word_valid), .fifo_fill_count(fifo_fill_count),
	.test_is_read(test_is_read), .fill_busy(fill_busy));
